// ---- ldp_pkg.sv ----
package ldp_pkg;

  // Register offsets
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_FC_OUTER  = 8'h01;
  localparam logic [7:0] REG_FC_CENTER = 8'h02;
  localparam logic [7:0] REG_INDICATOR = 8'h03;
  localparam logic [7:0] REG_VOUT      = 8'h04;
  localparam logic [7:0] REG_STATUS    = 8'h05;
  localparam logic [7:0] REG_BATMON    = 8'h07;

  // Field positions
  localparam int CTRL_VM_EN_BIT   = 2;
  localparam int IND_LED_SEL_LSB  = 4;
  localparam int VOUT_TS_EN_BIT   = 4;
  localparam int BATMON_EN_BIT    = 3;
  localparam int STAT_WARN_BIT    = 0;
  localparam int STAT_HOT_BIT     = 1;
  localparam int STAT_FAIL_BIT    = 2;
  localparam int STAT_DIE_LSB     = 4;

  // Reset values
  localparam logic [7:0] RST_REG  = 8'h00;

  // Operating mode codes
  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_VIDEO = 2'h1;
  localparam logic [1:0] MODE_FLASH = 2'h2;
  localparam logic [1:0] MODE_VOLT  = 2'h3;

  // Die status codes
  localparam logic [1:0] DIE_COOL = 2'h0;
  localparam logic [1:0] DIE_WARM = 2'h1;
  localparam logic [1:0] DIE_HOT  = 2'h2;
  localparam logic [1:0] DIE_TSD  = 2'h3;

  // Output voltage codes at or above this select the high limit
  localparam logic [3:0] OVP_HIGH_MIN_CODE = 4'h5;

  // Timing
  localparam int CLK_HZ         = 10_000_000;
  localparam int CLK_PERIOD_NS  = 100;
  localparam int PWM_FREQ_HZ    = 30_000;
  localparam int PWM_CYCLES     = CLK_HZ / PWM_FREQ_HZ;
  localparam int RAMP_UP_NS     = 12_000;
  localparam int RAMP_DOWN_NS   = 500;
  localparam int RAMP_UP_CYCLES = (RAMP_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAMP_DN_CYCLES = (RAMP_DOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWM_STEPS      = 16;

endpackage

// ---- ldp_sync.sv ----
`timescale 1ns/10ps
module ldp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta;

  // Two flops per bit; the first is read only by the second
  for (genvar b = 0; b < W; b++) begin : g_bit
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        meta[b]   <= 1'b0;
        o_sync[b] <= 1'b0;
      end else begin
        meta[b]   <= i_async[b];
        o_sync[b] <= meta[b];
      end
    end
  end

endmodule

// ---- ldp_ctrl.sv ----
`timescale 1ns/10ps
module ldp_ctrl
  import ldp_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // Register port
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_rd,
  output logic      [7:0] o_reg_rdata,
  // Comparator and pin inputs
  input  wire logic       i_ts_below_warn,
  input  wire logic       i_ts_below_hot,
  input  wire logic       i_led_short,
  input  wire logic       i_ovp_clamp,
  input  wire logic       i_batt_droop,
  input  wire logic       i_uvlo,
  input  wire logic       i_die_warm,
  input  wire logic       i_die_hot,
  input  wire logic       i_die_tsd,
  input  wire logic       i_tx_mask,
  // Power stage and sink controls
  output logic            o_switch_en,
  output logic            o_rect_en,
  output logic      [2:0] o_led_sink_en,
  output logic      [4:0] o_current_outer,
  output logic      [5:0] o_current_center,
  output logic            o_ovp_high,
  output logic            o_safety_timeout_en,
  output logic            o_ts_bias_en,
  // Battery droop monitor controls
  output logic            o_batt_sample,
  output logic            o_droop_mon_en,
  output logic      [2:0] o_droop_tolerance
);

  localparam int NSYNC = 10;

  // Control registers
  logic [1:0] mode;
  logic       voltage_mode_enable;
  logic [4:0] flash_current_outer;
  logic [5:0] flash_current_center;
  logic [3:0] indicator_level;
  logic [2:0] led_select;
  logic [3:0] output_voltage_code;
  logic       thermistor_enable;
  logic [2:0] droop_tolerance;
  logic       battery_monitor_enable;
  // Status
  logic       led_temp_warning;
  logic       led_overheat;
  logic       led_failure_flag;
  logic [1:0] die_temp_status;
  // Internal
  logic [NSYNC-1:0] s_in;
  logic       s_ts_warn, s_ts_hot, s_short, s_ovp, s_droop;
  logic       s_uvlo, s_warm, s_hot, s_tsd, s_tx;
  logic       tsd_q, flash_q, ramp_hold;
  logic [8:0] pwm_cnt;
  logic [6:0] up_cnt;
  logic [2:0] dn_cnt;
  logic       up_tick, dn_tick;
  logic       wr_ctrl, rd_status;
  logic       shutdown, regulating, volt_op, dimming, ts_active, flash;
  logic       tsd_rise, hot_evt, pwm_on, power_ok, droop_mon;
  logic [1:0] live_die;
  logic [5:0] cur [0:1];
  logic [5:0] tgt [0:1];

  // Comparator results cross into the clock domain first
  ldp_sync #(.W(NSYNC)) u_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_async ({i_ts_below_warn, i_ts_below_hot, i_led_short, i_ovp_clamp,
               i_batt_droop, i_uvlo, i_die_warm, i_die_hot, i_die_tsd,
               i_tx_mask}),
    .o_sync  (s_in)
  );
  assign {s_ts_warn, s_ts_hot, s_short, s_ovp, s_droop,
          s_uvlo, s_warm, s_hot, s_tsd, s_tx} = s_in;

  // Decoded conditions
  assign wr_ctrl    = i_reg_wr && (i_reg_addr == REG_CTRL);
  assign rd_status  = i_reg_rd && (i_reg_addr == REG_STATUS);
  assign volt_op    = (mode == MODE_VOLT) || voltage_mode_enable;
  assign shutdown   = (mode == MODE_OFF) && !voltage_mode_enable;
  assign regulating = (mode == MODE_VIDEO) || (mode == MODE_FLASH);
  assign flash      = (mode == MODE_FLASH);
  assign dimming    = (mode == MODE_VIDEO) && voltage_mode_enable;
  assign ts_active  = regulating || ((mode == MODE_VOLT) && thermistor_enable);
  assign tsd_rise   = s_tsd && !tsd_q;
  assign hot_evt    = ts_active && regulating && s_ts_hot;
  assign power_ok   = !shutdown && !s_uvlo && !s_tsd;
  assign droop_mon  = battery_monitor_enable && !s_tx && flash;
  assign live_die   = s_hot ? DIE_HOT : (s_warm ? DIE_WARM : DIE_COOL);

  // Duty compare scales the counter by the step count, no divider needed
  assign pwm_on = ({4'h0, pwm_cnt} * 13'(PWM_STEPS)) <
                  (13'(indicator_level) * 13'(PWM_CYCLES));

  // Mode field: hardware suspension wins over a software write
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode <= MODE_OFF;
    end else if (hot_evt) begin
      mode <= MODE_OFF;
    end else if (tsd_rise && !volt_op) begin
      mode <= MODE_OFF;
    end else if (wr_ctrl) begin
      mode <= i_reg_wdata[1:0];
    end
  end

  // Plain software-owned registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      voltage_mode_enable    <= 1'b0;
      flash_current_outer    <= RST_REG[4:0];
      flash_current_center   <= RST_REG[5:0];
      indicator_level        <= RST_REG[3:0];
      led_select             <= RST_REG[2:0];
      output_voltage_code    <= RST_REG[3:0];
      thermistor_enable      <= 1'b0;
      droop_tolerance        <= RST_REG[2:0];
      battery_monitor_enable <= 1'b0;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        REG_CTRL: begin
          voltage_mode_enable <= i_reg_wdata[CTRL_VM_EN_BIT];
        end
        REG_FC_OUTER: begin
          flash_current_outer <= i_reg_wdata[4:0];
        end
        REG_FC_CENTER: begin
          flash_current_center <= i_reg_wdata[5:0];
        end
        REG_INDICATOR: begin
          indicator_level <= i_reg_wdata[3:0];
          led_select      <= i_reg_wdata[IND_LED_SEL_LSB +: 3];
        end
        REG_VOUT: begin
          output_voltage_code <= i_reg_wdata[3:0];
          thermistor_enable   <= i_reg_wdata[VOUT_TS_EN_BIT];
        end
        REG_BATMON: begin
          droop_tolerance        <= i_reg_wdata[2:0];
          battery_monitor_enable <= i_reg_wdata[BATMON_EN_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Read data; status read clears sticky bits in the block below
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        REG_CTRL:      o_reg_rdata <= {5'h00, voltage_mode_enable, mode};
        REG_FC_OUTER:  o_reg_rdata <= {3'h0, flash_current_outer};
        REG_FC_CENTER: o_reg_rdata <= {2'h0, flash_current_center};
        REG_INDICATOR: o_reg_rdata <= {1'b0, led_select, indicator_level};
        REG_VOUT:      o_reg_rdata <= {3'h0, thermistor_enable, output_voltage_code};
        REG_STATUS:    o_reg_rdata <= {2'h0, die_temp_status, 1'b0, led_failure_flag,
                                       led_overheat, led_temp_warning};
        REG_BATMON:    o_reg_rdata <= {4'h0, battery_monitor_enable, droop_tolerance};
        default:       o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // LED temperature flags; warning is live, overheat sticky until read
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      led_temp_warning <= 1'b0;
      led_overheat     <= 1'b0;
    end else begin
      led_temp_warning <= ts_active && s_ts_warn;
      if (hot_evt) begin
        led_overheat <= 1'b1;
      end else if (rd_status) begin
        led_overheat <= 1'b0;
      end
    end
  end

  // Open or short LED failure, sticky; a new fault beats the read clear
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      led_failure_flag <= 1'b0;
    end else if (!shutdown && s_ovp) begin
      led_failure_flag <= 1'b1;
    end else if (regulating && s_short) begin
      led_failure_flag <= 1'b1;
    end else if (rd_status) begin
      led_failure_flag <= 1'b0;
    end
  end

  // Die status: thermal trip holds 11 until read, else tracks live code while not shut down
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      die_temp_status <= DIE_COOL;
      tsd_q           <= 1'b0;
    end else begin
      tsd_q <= s_tsd;
      if (tsd_rise || hot_evt) begin
        die_temp_status <= DIE_TSD;
      end else if (die_temp_status == DIE_TSD) begin
        if (rd_status) begin
          die_temp_status <= shutdown ? DIE_COOL : live_die;
        end
      end else if (!shutdown) begin
        die_temp_status <= live_die;
      end
    end
  end

  // PWM period counter, free running off the core clock
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pwm_cnt <= 9'h000;
    end else if (pwm_cnt == 9'(PWM_CYCLES - 1)) begin
      pwm_cnt <= 9'h000;
    end else begin
      pwm_cnt <= pwm_cnt + 9'h001;
    end
  end

  // Ramp step enables: one pulse per step interval
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      up_cnt  <= 7'h00;
      dn_cnt  <= 3'h0;
      up_tick <= 1'b0;
      dn_tick <= 1'b0;
    end else begin
      up_tick <= (up_cnt == 7'(RAMP_UP_CYCLES - 1));
      dn_tick <= (dn_cnt == 3'(RAMP_DN_CYCLES - 1));
      up_cnt  <= (up_cnt == 7'(RAMP_UP_CYCLES - 1)) ? 7'h00 : up_cnt + 7'h01;
      dn_cnt  <= (dn_cnt == 3'(RAMP_DN_CYCLES - 1)) ? 3'h0 : dn_cnt + 3'h1;
    end
  end

  // Flash start detect, battery sample pulse and droop hold
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flash_q       <= 1'b0;
      o_batt_sample <= 1'b0;
      ramp_hold     <= 1'b0;
    end else begin
      flash_q       <= flash;
      o_batt_sample <= flash && !flash_q && battery_monitor_enable;
      if (!flash || !flash_q) begin
        ramp_hold <= 1'b0;
      end else if (droop_mon && s_droop) begin
        ramp_hold <= 1'b1;
      end
    end
  end

  // Targets drop to zero whenever the stage may not drive the LEDs
  assign tgt[0] = (regulating && power_ok) ? {1'b0, flash_current_outer} : 6'h00;
  assign tgt[1] = (regulating && power_ok) ? flash_current_center : 6'h00;

  // One step of 25 mA per LSB; up is held by droop, down never is
  for (genvar c = 0; c < 2; c++) begin : g_ramp
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        cur[c] <= 6'h00;
      end else if (!power_ok) begin
        cur[c] <= 6'h00;
      end else if ((cur[c] < tgt[c]) && up_tick && !ramp_hold) begin
        cur[c] <= cur[c] + 6'h01;
      end else if ((cur[c] > tgt[c]) && dn_tick) begin
        cur[c] <= cur[c] - 6'h01;
      end
    end
  end
  assign o_current_outer  = cur[0][4:0];
  assign o_current_center = cur[1];

  // Registered drive outputs
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_switch_en         <= 1'b0;
      o_rect_en           <= 1'b0;
      o_led_sink_en       <= 3'h0;
      o_ovp_high          <= 1'b0;
      o_safety_timeout_en <= 1'b0;
      o_ts_bias_en        <= 1'b0;
      o_droop_mon_en      <= 1'b0;
      o_droop_tolerance   <= 3'h0;
    end else begin
      o_switch_en         <= power_ok;
      o_rect_en           <= power_ok;
      o_led_sink_en       <= {3{regulating && power_ok && (!dimming || pwm_on)}}
                             & led_select;
      o_ovp_high          <= (output_voltage_code >= OVP_HIGH_MIN_CODE);
      o_safety_timeout_en <= (mode == MODE_VIDEO) && !dimming;
      o_ts_bias_en        <= ts_active;
      o_droop_mon_en      <= droop_mon;
      o_droop_tolerance   <= droop_tolerance;
    end
  end

endmodule

// ---- ldp_ctrl_assertions.sv ----
`timescale 1ns/10ps
module ldp_ctrl_assertions
  import ldp_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // Register port
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_wdata,
  // Comparator inputs
  input  wire logic       i_uvlo,
  input  wire logic       i_die_tsd,
  input  wire logic       i_tx_mask,
  // Observed outputs
  input  wire logic       o_switch_en,
  input  wire logic       o_rect_en,
  input  wire logic [2:0] o_led_sink_en,
  input  wire logic [4:0] o_current_outer,
  input  wire logic       o_ovp_high,
  input  wire logic       o_batt_sample,
  input  wire logic       o_droop_mon_en
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  logic [4:0] prev_outer;
  logic [7:0] since_up;
  logic [7:0] since_dn;
  logic [3:0] last_code;

  // Step spacing counters; they saturate so a long idle never wraps into a false gap
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_outer <= 5'h00;
      since_up   <= 8'hFF;
      since_dn   <= 8'hFF;
    end else begin
      prev_outer <= o_current_outer;
      since_up   <= (o_current_outer > prev_outer) ? 8'h00 : since_up + {7'h00, since_up != 8'hFF};
      since_dn   <= (o_current_outer < prev_outer) ? 8'h00 : since_dn + {7'h00, since_dn != 8'hFF};
    end
  end

  // Last output voltage code written
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      last_code <= 4'h0;
    end else if (i_reg_wr && i_reg_addr == REG_VOUT) begin
      last_code <= i_reg_wdata[3:0];
    end
  end

  a_uvlo_gates_off: assert property (i_uvlo [*4] |-> !o_switch_en && !o_rect_en)
    else $error("gate drive on during undervoltage");
  a_tsd_stage_off: assert property (i_die_tsd [*4] |->
    !o_switch_en && o_led_sink_en == 3'h0 && o_current_outer == 5'h00)
    else $error("power stage on during thermal shutdown");
  a_ovp_limit_code: assert property ((i_reg_wr && i_reg_addr == REG_VOUT) |->
    ##2 (o_ovp_high == (last_code >= OVP_HIGH_MIN_CODE)))
    else $error("overvoltage limit does not follow code");
  a_sample_one_pulse: assert property (o_batt_sample |=> !o_batt_sample)
    else $error("battery sample longer than one cycle");
  a_mask_stops_droop: assert property (i_tx_mask [*4] |-> !o_droop_mon_en)
    else $error("droop monitor active under transmit mask");
  a_ramp_up_step: assert property ((o_current_outer > prev_outer) |->
    o_current_outer == prev_outer + 5'h01)
    else $error("ramp up step not one unit");
  a_ramp_up_gap: assert property ((o_current_outer > prev_outer) |-> since_up >= 8'h77)
    else $error("ramp up steps too close");
  a_ramp_dn_gap: assert property ((o_current_outer < prev_outer) &&
    (o_current_outer != 5'h00) |-> since_dn >= 8'h04 && o_current_outer == prev_outer - 5'h01)
    else $error("ramp down step wrong");

  c_batt_sample: cover property (o_batt_sample);
  c_ramp_up: cover property (o_current_outer > prev_outer);
  c_ovp_high: cover property (o_ovp_high);
endmodule

bind ldp_ctrl ldp_ctrl_assertions u_chk (.*);

// ---- ldp_host.sv ----
`timescale 1ns/10ps
module ldp_host (
  // Clock
  input  wire logic       i_clk,
  // Register port toward the device
  output logic      [7:0] o_reg_addr,
  output logic            o_reg_wr,
  output logic      [7:0] o_reg_wdata,
  output logic            o_reg_rd
);
  // Idle bus at time zero
  initial begin
    o_reg_addr  = 8'h00;
    o_reg_wr    = 1'b0;
    o_reg_wdata = 8'h00;
    o_reg_rd    = 1'b0;
  end

  // One write; address and data are inverted afterwards so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_reg_addr  <= a;
    o_reg_wdata <= d;
    o_reg_wr    <= 1'b1;
    @(posedge i_clk);
    o_reg_wr    <= 1'b0;
    o_reg_addr  <= ~a;
    o_reg_wdata <= ~d;
  endtask

  // One read; data is taken by the bench monitor
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    o_reg_addr <= a;
    o_reg_rd   <= 1'b1;
    @(posedge i_clk);
    o_reg_rd   <= 1'b0;
    o_reg_addr <= ~a;
  endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module tb_top
  import ldp_pkg::*;
;
  logic       i_clk = 1'b0;
  logic       i_rst_b;
  logic [9:0] cmp;
  logic [7:0] reg_addr, reg_wdata, rdata, exp_v;
  logic       reg_wr, reg_rd, rd_d, sw_en, rect_en, ovp_high, mon_en;
  logic [2:0] sinks, tol;
  logic [4:0] cur_outer;
  logic [5:0] cur_center;
  logic       tmo_en, ts_bias, batt_smp, prev_on;
  int         on_cnt = 0;
  int         rise_cnt = 0;
  int         odd_cnt = 0;
  int         samp_cnt = 0;
  logic [31:0] seed;
  logic [7:0] exp_q[$];
  int         fail_count = 0;
  int         check_count = 0;
  logic [7:0] addrs[5] = '{REG_FC_OUTER, REG_FC_CENTER, REG_INDICATOR, REG_VOUT, REG_BATMON};
  logic [7:0] masks[5] = '{8'h1F, 8'h3F, 8'h7F, 8'h1F, 8'h0F};

  // 10 MHz core clock
  always #50 i_clk = ~i_clk;

  ldp_host u_host (.i_clk(i_clk), .o_reg_addr(reg_addr), .o_reg_wr(reg_wr),
    .o_reg_wdata(reg_wdata), .o_reg_rd(reg_rd));

  ldp_ctrl u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_addr(reg_addr),
    .i_reg_wr(reg_wr), .i_reg_wdata(reg_wdata), .i_reg_rd(reg_rd), .o_reg_rdata(rdata),
    .i_ts_below_warn(cmp[0]), .i_ts_below_hot(cmp[1]), .i_led_short(cmp[2]),
    .i_ovp_clamp(cmp[3]), .i_batt_droop(cmp[4]), .i_uvlo(cmp[5]), .i_die_warm(cmp[6]),
    .i_die_hot(cmp[7]), .i_die_tsd(cmp[8]), .i_tx_mask(cmp[9]), .o_switch_en(sw_en),
    .o_rect_en(rect_en), .o_led_sink_en(sinks), .o_current_outer(cur_outer),
    .o_current_center(cur_center), .o_ovp_high(ovp_high), .o_safety_timeout_en(tmo_en),
    .o_ts_bias_en(ts_bias), .o_batt_sample(batt_smp), .o_droop_mon_en(mon_en),
    .o_droop_tolerance(tol));

  // Read results land on the edge that takes the strobe; checked at the next falling edge
  always @(posedge i_clk) rd_d <= reg_rd;
  always @(negedge i_clk) begin
    if (rd_d === 1'b1) begin
      exp_v = exp_q.pop_front();
      `CHK(rdata, exp_v)
    end
  end

  // Battery sample pulses seen at the pin; a stretched pulse would count once per cycle
  always @(posedge i_clk) begin
    if (batt_smp === 1'b1) samp_cnt++;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic end_of_test();
    if (fail_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.rd(a);
    @(posedge i_clk);
  endtask

  // Comparator level change, then enough edges for the two-flop path
  task automatic set_cmp(input int b, input logic v);
    @(posedge i_clk);
    cmp[b] <= v;
    repeat (5) @(posedge i_clk);
  endtask

  task automatic do_reset();
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    for (int a = 0; a < 9; a++) rdx(a[7:0], 8'h00);
  endtask

  // Hang guard, far beyond the few thousand cycles the sequence needs
  initial begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    end_of_test();
  end

  initial begin
    i_rst_b = 1'b0;
    cmp = 10'h000;
    seed = 32'hCF59;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      seed = xs(seed);
      u_host.wr(addrs[i], seed[7:0]);
      rdx(addrs[i], seed[7:0] & masks[i]);
    end
    // A warm die is not reported while shut down
    set_cmp(6, 1'b1);
    u_host.wr(REG_STATUS, 8'hFF);
    rdx(REG_STATUS, 8'h00);
    set_cmp(6, 1'b0);
    do_reset();
    // Every output voltage code across the limit boundary
    for (int c = 0; c < 16; c++) begin
      u_host.wr(REG_VOUT, {4'h0, c[3:0]});
      repeat (2) @(negedge i_clk);
      `CHK(ovp_high, (c >= 5))
    end
    u_host.wr(REG_CTRL, {6'h00, MODE_VIDEO});
    u_host.wr(REG_INDICATOR, 8'h70);
    // Short and clamp both leave a sticky failure flag cleared by reading
    for (int b = 2; b < 4; b++) begin
      set_cmp(b, 1'b1);
      set_cmp(b, 1'b0);
      rdx(REG_STATUS, 8'h04);
      rdx(REG_STATUS, 8'h00);
    end
    set_cmp(0, 1'b1);
    rdx(REG_STATUS, 8'h01);
    set_cmp(0, 1'b0);
    set_cmp(6, 1'b1);
    rdx(REG_STATUS, 8'h10);
    set_cmp(7, 1'b1);
    rdx(REG_STATUS, 8'h20);
    set_cmp(6, 1'b0);
    set_cmp(7, 1'b0);
    // Plain video: all selected sinks on, safety timer and thermistor live
    `CHK(sinks, 3'h7)
    `CHK(tmo_en, 1'b1)
    `CHK(ts_bias, 1'b1)
    set_cmp(5, 1'b1);
    `CHK({sw_en, rect_en}, 2'b00)
    set_cmp(5, 1'b0);
    set_cmp(8, 1'b1);
    `CHK(sinks, 3'h0)
    rdx(REG_STATUS, 8'h30);
    rdx(REG_CTRL, 8'h00);
    set_cmp(8, 1'b0);
    rdx(REG_STATUS, 8'h00);
    u_host.wr(REG_CTRL, {6'h00, MODE_VIDEO});
    set_cmp(1, 1'b1);
    rdx(REG_STATUS, 8'h32);
    rdx(REG_CTRL, 8'h00);
    set_cmp(1, 1'b0);
    u_host.wr(REG_CTRL, 8'h07);
    set_cmp(8, 1'b1);
    set_cmp(8, 1'b0);
    rdx(REG_CTRL, 8'h07);
    `CHK(sw_en, 1'b1)
    `CHK(ts_bias, 1'b0)
    u_host.wr(REG_VOUT, 8'h10);
    repeat (2) @(negedge i_clk);
    `CHK(ts_bias, 1'b1)
    // Dimming at level 8 on LEDs 1 and 3, watched over three PWM periods
    u_host.wr(REG_INDICATOR, 8'h58);
    u_host.wr(REG_CTRL, 8'h05);
    repeat (2) @(negedge i_clk);
    prev_on = sinks[0];
    repeat (3 * PWM_CYCLES) begin
      @(negedge i_clk);
      if (sinks != 3'h0) on_cnt++;
      if (sinks != 3'h0 && sinks != 3'h5) odd_cnt++;
      if (sinks[0] && !prev_on) rise_cnt++;
      prev_on = sinks[0];
    end
    `CHK(rise_cnt, 3)
    `CHK(on_cnt * PWM_STEPS + 3 * PWM_STEPS >= 3 * 8 * PWM_CYCLES, 1'b1)
    `CHK(on_cnt * PWM_STEPS <= 3 * 8 * PWM_CYCLES + 3 * PWM_STEPS, 1'b1)
    `CHK(odd_cnt, 0)
    `CHK(tmo_en, 1'b0)
    // Flash ramp with droop reported but the monitor off, then a ramp down
    u_host.wr(REG_CTRL, 8'h00);
    u_host.wr(REG_BATMON, 8'h03);
    u_host.wr(REG_FC_OUTER, 8'h02);
    u_host.wr(REG_FC_CENTER, 8'h02);
    set_cmp(4, 1'b1);
    u_host.wr(REG_CTRL, {6'h00, MODE_FLASH});
    repeat (300) @(negedge i_clk);
    `CHK(cur_outer, 5'h02)
    `CHK(cur_center, 6'h02)
    `CHK(samp_cnt, 0)
    u_host.wr(REG_FC_OUTER, 8'h00);
    repeat (14) @(negedge i_clk);
    `CHK(cur_outer, 5'h00)
    // Monitor on: droop at flash start freezes the ramp below target
    u_host.wr(REG_CTRL, 8'h00);
    u_host.wr(REG_BATMON, 8'h0B);
    u_host.wr(REG_FC_OUTER, 8'h02);
    u_host.wr(REG_CTRL, {6'h00, MODE_FLASH});
    repeat (300) @(negedge i_clk);
    `CHK(cur_outer < 5'h02, 1'b1)
    `CHK(cur_center < 6'h02, 1'b1)
    `CHK(samp_cnt, 1)
    `CHK(tol, 3'h3)
    `CHK(mon_en, 1'b1)
    set_cmp(9, 1'b1);
    `CHK(mon_en, 1'b0)
    set_cmp(9, 1'b0);
    end_of_test();
  end
endmodule
